// ==== pkg/dma_pkg.sv ====
`default_nettype none
package dma_pkg;

   // -----------------------------------------------------------------
   // Widths
   // -----------------------------------------------------------------
   localparam int DATA_W = 16;
   localparam int ADDR_W = 16;
   localparam int CNT_W  = 16;
   localparam int REG_AW = 4;
   localparam int TRIG_N = 16;
   localparam int TSEL_W = 4;

   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [REG_AW-1:0] CTRL_OFS = 4'h0;
   localparam logic [REG_AW-1:0] SRC_OFS  = 4'h2;
   localparam logic [REG_AW-1:0] DST_OFS  = 4'h4;
   localparam logic [REG_AW-1:0] CNT_OFS  = 4'h6;
   localparam logic [REG_AW-1:0] TSEL_OFS = 4'h8;

   // -----------------------------------------------------------------
   // Control word fields
   // -----------------------------------------------------------------
   localparam int MODE_LSB     = 0;
   localparam int SRC_STEP_LSB = 3;
   localparam int DST_STEP_LSB = 5;
   localparam int SRC_BYTE_BIT = 7;
   localparam int DST_BYTE_BIT = 8;
   localparam int LEVEL_BIT    = 9;
   localparam int EN_BIT       = 10;
   localparam int REQ_BIT      = 11;
   localparam int DONE_BIT     = 12;
   localparam int NMI_EN_BIT   = 13;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
   localparam logic [CNT_W-1:0]  CNT_RESET  = 16'h0000;
   localparam logic [TSEL_W-1:0] TSEL_RESET = 4'h0;

   // -----------------------------------------------------------------
   // Modes, steps, timing
   // -----------------------------------------------------------------
   localparam logic [1:0] KIND_SINGLE = 2'b00;
   localparam logic [1:0] KIND_BLOCK  = 2'b01;
   localparam logic [1:0] STEP_DEC    = 2'b10;
   localparam logic [1:0] STEP_INC    = 2'b11;
   localparam logic [TSEL_W-1:0] TSEL_SOFT = 4'h0;
   localparam logic [1:0] BURST_LAST  = 2'b11;
   localparam logic       GAP_LAST    = 1'b1;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_READ  = 4'b0010,
      ST_WRITE = 4'b0100,
      ST_GAP   = 4'b1000
   } state_type;

endpackage : dma_pkg
`default_nettype wire

// ==== pkg/step_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface step_if #(parameter int AW = 16);
   logic [AW-1:0] addr;
   logic [AW-1:0] next_addr;
   logic [1:0]    sel;
   logic          is_byte;
   modport user    (output addr, output sel, output is_byte, input next_addr);
   modport stepper (input addr, input sel, input is_byte, output next_addr);
endinterface : step_if
`default_nettype wire

// ==== design/addr_stepper.sv ====
`timescale 1ns/10ps
`default_nettype none
module addr_stepper #(
   parameter int AW = 16
) (
   step_if.stepper s
);
   import dma_pkg::*;

   logic [AW-1:0] amount;

   always_comb begin
      // Byte steps one, word steps two
      // Step by width
      amount = s.is_byte ? AW'(1) : AW'(2);
      unique case (s.sel)
         STEP_INC: s.next_addr = s.addr + amount;
         STEP_DEC: s.next_addr = s.addr - amount;
         default:  s.next_addr = s.addr;
      endcase
   end

endmodule : addr_stepper
`default_nettype wire

// ==== design/dma_transfer_mode_engine.sv ====
`timescale 1ns/10ps
`default_nettype none
//Contract
// - Three-bit mode: single, block, burst-block, each one-shot or repeated.
// - Transfer mode works independently of any addressing mode.
// - Source and destination each selectable as byte or word.
// - Single modes move one unit per accepted trigger.
// - Zero count means no transfers in any mode.
// - Addresses and count copied at start; only working addresses step.
// - Count decrements per transfer; at zero reloads and sets done flag.
// - One-shot single clears enable when count reaches zero.
// - Repeated single keeps enable; each trigger moves one more unit.
// - One-shot block moves whole block per trigger, then clears enable.
// - Triggers during a running block or burst sequence are ignored.
// - CPU halted during block, two clocks per transfer.
// - Repeated block keeps enable; next trigger starts new block.
// - Burst modes free the CPU two clocks after every four transfers; the count restarts each block and a repeated relaunch gets no gap.
// - One-shot burst end frees CPU fully and clears enable.
// - Repeated burst restarts at once without trigger.
// - Repeated burst stops on enable clear or NMI with abort enabled.
// - With edge setting, trigger already high when selected starts nothing; wait for new edge.
// - Word to byte writes low byte; byte to word zeroes upper byte.
// - Two-bit source and destination step selects: inc, dec, hold.
// - With edge setting, rising edge of selected trigger starts work.
// - Select zero uses soft request bit, cleared when transfer starts.
module dma_transfer_mode_engine #(
   parameter int ADDR_W = dma_pkg::ADDR_W,
   parameter int CNT_W  = dma_pkg::CNT_W,
   parameter int TRIG_N = dma_pkg::TRIG_N
) (
   // Clock and reset
   input  wire  logic                       CLK_I,
   input  wire  logic                       RST_I,
   // Register port
   input  wire  logic [dma_pkg::REG_AW-1:0] REG_ADDR_I,
   input  wire  logic [dma_pkg::DATA_W-1:0] REG_WDATA_I,
   input  wire  logic                       REG_WR_I,
   input  wire  logic                       REG_RD_I,
   output logic       [dma_pkg::DATA_W-1:0] REG_RDATA_O,
   // Trigger and NMI pins
   input  wire  logic [TRIG_N-1:0]          TRIG_I,
   input  wire  logic                       NMI_I,
   // System bus master
   output logic       [ADDR_W-1:0]          MEM_ADDR_O,
   output logic                             MEM_RD_O,
   output logic                             MEM_WR_O,
   output logic                             MEM_BYTE_O,
   output logic       [dma_pkg::DATA_W-1:0] MEM_WDATA_O,
   input  wire  logic [dma_pkg::DATA_W-1:0] MEM_RDATA_I,
   // CPU and status
   output logic                             CPU_HALT_O,
   output logic                             DONE_O,
   output logic                             ENABLE_O
);
   import dma_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      state_type           state;
      logic [2:0]          mode;
      logic [1:0]          src_step;
      logic [1:0]          dst_step;
      logic                src_byte;
      logic                dst_byte;
      logic                level;
      logic                en;
      logic                req;
      logic                done;
      logic                nmi_en;
      logic [TSEL_W-1:0]   tsel;
      logic [ADDR_W-1:0]   src_reg;
      logic [ADDR_W-1:0]   dst_reg;
      logic [CNT_W-1:0]    cnt_reg;
      logic [ADDR_W-1:0]   src_w;
      logic [ADDR_W-1:0]   dst_w;
      logic [CNT_W-1:0]    size_w;
      logic                loaded;
      logic [1:0]          burst_cnt;
      logic                gap_cnt;
      logic [TRIG_N-1:0]   trig_s1;
      logic [TRIG_N-1:0]   trig_s2;
      logic [TRIG_N-1:0]   trig_prev;
      logic                nmi_s1;
      logic                nmi_s2;
      logic                nmi_prev;
      logic [DATA_W-1:0]   rdata;
      logic [ADDR_W-1:0]   mem_addr;
      logic                mem_rd;
      logic                mem_wr;
      logic                mem_byte;
      logic [DATA_W-1:0]   mem_wdata;
      logic                halt;
   } core_type;

   core_type r_reg;
   core_type r_next;

   logic              kind_single;
   logic              kind_block;
   logic              kind_burst;
   logic              repeated;
   logic              trig_hit;
   logic              nmi_abort;
   logic              last_xfer;
   logic              launch;
   logic              done_set;
   logic [DATA_W-1:0] ctrl_word;

   // ----------------------------------------------------------------
   // Address steppers
   // ----------------------------------------------------------------
   step_if #(.AW(ADDR_W)) src_if ();
   step_if #(.AW(ADDR_W)) dst_if ();

   assign src_if.addr    = r_reg.src_w;
   assign src_if.sel     = r_reg.src_step;
   assign src_if.is_byte = r_reg.src_byte;
   assign dst_if.addr    = r_reg.dst_w;
   assign dst_if.sel     = r_reg.dst_step;
   assign dst_if.is_byte = r_reg.dst_byte;

   addr_stepper #(.AW(ADDR_W)) u_src_step (.s(src_if.stepper));
   addr_stepper #(.AW(ADDR_W)) u_dst_step (.s(dst_if.stepper));

   // ----------------------------------------------------------------
   // Mode decode and trigger detect
   // ----------------------------------------------------------------
   always_comb begin
      kind_single = (r_reg.mode[1:0] == KIND_SINGLE);
      kind_block  = (r_reg.mode[1:0] == KIND_BLOCK);
      kind_burst  = r_reg.mode[1];
      repeated    = r_reg.mode[2];
      if (r_reg.tsel == TSEL_SOFT) begin
         trig_hit = r_reg.req;
      end else if (r_reg.level) begin
         trig_hit = r_reg.trig_s2[r_reg.tsel];
      end else begin
         trig_hit = r_reg.trig_s2[r_reg.tsel] & ~r_reg.trig_prev[r_reg.tsel];
      end
      nmi_abort = r_reg.nmi_en & r_reg.nmi_s2 & ~r_reg.nmi_prev;
      last_xfer = (r_reg.cnt_reg == CNT_W'(1));
      ctrl_word = '0;
      ctrl_word[MODE_LSB +: 3]     = r_reg.mode;
      ctrl_word[SRC_STEP_LSB +: 2] = r_reg.src_step;
      ctrl_word[DST_STEP_LSB +: 2] = r_reg.dst_step;
      ctrl_word[SRC_BYTE_BIT]      = r_reg.src_byte;
      ctrl_word[DST_BYTE_BIT]      = r_reg.dst_byte;
      ctrl_word[LEVEL_BIT]         = r_reg.level;
      ctrl_word[EN_BIT]            = r_reg.en;
      ctrl_word[REQ_BIT]           = r_reg.req;
      ctrl_word[DONE_BIT]          = r_reg.done;
      ctrl_word[NMI_EN_BIT]        = r_reg.nmi_en;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      r_next          = r_reg;
      launch          = 1'b0;
      done_set        = 1'b0;
      r_next.trig_s1  = TRIG_I;
      r_next.trig_s2  = r_reg.trig_s1;
      r_next.trig_prev = r_reg.trig_s2;
      r_next.nmi_s1   = NMI_I;
      r_next.nmi_s2   = r_reg.nmi_s1;
      r_next.nmi_prev = r_reg.nmi_s2;
      r_next.mem_rd   = 1'b0;
      r_next.mem_wr   = 1'b0;
      r_next.rdata    = '0;
      if (!r_reg.en) begin
         r_next.loaded = 1'b0;
      end

      unique case (r_reg.state)
         ST_IDLE: begin
            r_next.halt = 1'b0;
            if (r_reg.en && trig_hit && (r_reg.loaded || r_reg.cnt_reg != '0)) begin
               launch = 1'b1;
            end
         end
         ST_READ: begin
            r_next.mem_wdata = (r_reg.src_byte | r_reg.dst_byte) ?
                               {8'h00, MEM_RDATA_I[7:0]} : MEM_RDATA_I;
            r_next.mem_addr  = r_reg.dst_w;
            r_next.mem_byte  = r_reg.dst_byte;
            r_next.mem_wr    = 1'b1;
            r_next.state     = ST_WRITE;
         end
         ST_WRITE: begin
            r_next.src_w     = src_if.next_addr;
            r_next.dst_w     = dst_if.next_addr;
            r_next.cnt_reg   = r_reg.cnt_reg - CNT_W'(1);
            r_next.burst_cnt = r_reg.burst_cnt + 2'b01;
            r_next.state     = ST_IDLE;
            r_next.halt      = 1'b0;
            if (last_xfer) begin
               r_next.cnt_reg   = r_reg.size_w;
               r_next.loaded    = 1'b0;
               r_next.burst_cnt = '0;
               done_set         = 1'b1;
               if (!repeated) begin
                  r_next.en = 1'b0;
               end else if (kind_burst && r_reg.en) begin
                  launch = 1'b1;
               end
            end else if (kind_single || !r_reg.en) begin
               r_next.state = ST_IDLE;
            end else if (kind_burst && r_reg.burst_cnt == BURST_LAST) begin
               r_next.state   = ST_GAP;
               r_next.gap_cnt = 1'b0;
            end else begin
               r_next.mem_addr = src_if.next_addr;
               r_next.mem_byte = r_reg.src_byte;
               r_next.mem_rd   = 1'b1;
               r_next.halt     = 1'b1;
               r_next.state    = ST_READ;
            end
         end
         ST_GAP: begin
            r_next.gap_cnt = ~r_reg.gap_cnt;
            if (!r_reg.en) begin
               r_next.state = ST_IDLE;
            end else if (r_reg.gap_cnt == GAP_LAST) begin
               r_next.mem_addr = r_reg.src_w;
               r_next.mem_byte = r_reg.src_byte;
               r_next.mem_rd   = 1'b1;
               r_next.halt     = 1'b1;
               r_next.state    = ST_READ;
            end
         end
         default: begin
            r_next.state = ST_IDLE;
            r_next.halt  = 1'b0;
         end
      endcase

      if (launch) begin
         if (!r_reg.loaded || r_reg.state == ST_WRITE) begin
            r_next.src_w    = r_reg.src_reg;
            r_next.dst_w    = r_reg.dst_reg;
            r_next.size_w   = r_reg.state == ST_WRITE ? r_reg.size_w : r_reg.cnt_reg;
            r_next.mem_addr = r_reg.src_reg;
         end else begin
            r_next.mem_addr = r_reg.src_w;
         end
         r_next.loaded    = 1'b1;
         r_next.burst_cnt = '0;
         r_next.mem_byte  = r_reg.src_byte;
         r_next.mem_rd    = 1'b1;
         r_next.halt      = 1'b1;
         r_next.state     = ST_READ;
         if (r_reg.tsel == TSEL_SOFT) begin
            r_next.req = 1'b0;
         end
      end

      if (nmi_abort) begin
         r_next.en     = 1'b0;
         r_next.loaded = 1'b0;
         r_next.mem_rd = 1'b0;
         if (r_reg.state != ST_READ) begin
            r_next.halt  = 1'b0;
            r_next.state = ST_IDLE;
         end
      end

      // Register writes
      if (REG_WR_I) begin
         unique case (REG_ADDR_I)
            CTRL_OFS: begin
               r_next.mode     = REG_WDATA_I[MODE_LSB +: 3];
               r_next.src_step = REG_WDATA_I[SRC_STEP_LSB +: 2];
               r_next.dst_step = REG_WDATA_I[DST_STEP_LSB +: 2];
               r_next.src_byte = REG_WDATA_I[SRC_BYTE_BIT];
               r_next.dst_byte = REG_WDATA_I[DST_BYTE_BIT];
               r_next.level    = REG_WDATA_I[LEVEL_BIT];
               r_next.en       = REG_WDATA_I[EN_BIT];
               r_next.req      = REG_WDATA_I[REQ_BIT];
               r_next.done     = REG_WDATA_I[DONE_BIT];
               r_next.nmi_en   = REG_WDATA_I[NMI_EN_BIT];
            end
            SRC_OFS:  r_next.src_reg = REG_WDATA_I[ADDR_W-1:0];
            DST_OFS:  r_next.dst_reg = REG_WDATA_I[ADDR_W-1:0];
            CNT_OFS:  r_next.cnt_reg = REG_WDATA_I[CNT_W-1:0];
            TSEL_OFS: r_next.tsel    = REG_WDATA_I[TSEL_W-1:0];
            default:  r_next.tsel    = r_next.tsel;
         endcase
      end
      // Hardware set beats software clear
      if (done_set) begin
         r_next.done = 1'b1;
      end

      // Register reads
      if (REG_RD_I) begin
         unique case (REG_ADDR_I)
            CTRL_OFS: r_next.rdata = ctrl_word;
            SRC_OFS:  r_next.rdata = DATA_W'(r_reg.src_reg);
            DST_OFS:  r_next.rdata = DATA_W'(r_reg.dst_reg);
            CNT_OFS:  r_next.rdata = DATA_W'(r_reg.cnt_reg);
            TSEL_OFS: r_next.rdata = DATA_W'(r_reg.tsel);
            default:  r_next.rdata = '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         r_reg          <= '0;
         r_reg.state    <= ST_IDLE;
         r_reg.mode     <= CTRL_RESET[MODE_LSB +: 3];
         r_reg.src_reg  <= ADDR_RESET;
         r_reg.dst_reg  <= ADDR_RESET;
         r_reg.cnt_reg  <= CNT_RESET;
         r_reg.tsel     <= TSEL_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign REG_RDATA_O = r_reg.rdata;
   assign MEM_ADDR_O  = r_reg.mem_addr;
   assign MEM_RD_O    = r_reg.mem_rd;
   assign MEM_WR_O    = r_reg.mem_wr;
   assign MEM_BYTE_O  = r_reg.mem_byte;
   assign MEM_WDATA_O = r_reg.mem_wdata;
   assign CPU_HALT_O  = r_reg.halt;
   assign DONE_O      = r_reg.done;
   assign ENABLE_O    = r_reg.en;

endmodule : dma_transfer_mode_engine
`default_nettype wire

// ==== test/dma_mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module dma_mem_model (
   // Bus side
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        rd_i,
   input  wire logic        wr_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [15:0] wdata_i,
   output logic      [15:0] rdata_o,
   // Write log
   output var  int          wr_cnt_o,
   output logic      [15:0] wr_addr_o,
   output logic      [15:0] wr_data_o
);
   // ------
   // Same-cycle read, other pattern when idle
   // ------
   always_comb
      rdata_o = rd_i ? {~addr_i[7:0], addr_i[7:0]} : {addr_i[7:0], ~addr_i[7:0]};

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_cnt_o  <= 0;
         wr_addr_o <= 16'h0000;
         wr_data_o <= 16'h0000;
      end else if (wr_i) begin
         wr_cnt_o  <= wr_cnt_o + 1;
         wr_addr_o <= addr_i;
         wr_data_o <= wdata_i;
      end
   end
endmodule : dma_mem_model
`default_nettype wire

// ==== test/dma_transfer_mode_engine_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module dma_transfer_mode_engine_sva #(
   parameter int ADDR_W = 16,
   parameter int CNT_W  = 16,
   parameter int TRIG_N = 16
) (
   // Clock and reset
   input wire logic                       CLK_I,
   input wire logic                       RST_I,
   // Register port
   input wire logic [dma_pkg::REG_AW-1:0] REG_ADDR_I,
   input wire logic [dma_pkg::DATA_W-1:0] REG_WDATA_I,
   input wire logic                       REG_WR_I,
   input wire logic                       REG_RD_I,
   input wire logic [dma_pkg::DATA_W-1:0] REG_RDATA_O,
   // Pins
   input wire logic [TRIG_N-1:0]          TRIG_I,
   input wire logic                       NMI_I,
   // Bus
   input wire logic [ADDR_W-1:0]          MEM_ADDR_O,
   input wire logic                       MEM_RD_O,
   input wire logic                       MEM_WR_O,
   input wire logic                       MEM_BYTE_O,
   input wire logic [dma_pkg::DATA_W-1:0] MEM_WDATA_O,
   input wire logic [dma_pkg::DATA_W-1:0] MEM_RDATA_I,
   // Status
   input wire logic                       CPU_HALT_O,
   input wire logic                       DONE_O,
   input wire logic                       ENABLE_O
);
   import dma_pkg::*;
   logic [2:0] mode_q;
   logic [3:0] rd_n;

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         mode_q <= 3'h0;
         rd_n   <= 4'h0;
      end else begin
         if (REG_WR_I && REG_ADDR_I == CTRL_OFS)
            mode_q <= REG_WDATA_I[2:0];
         if (!CPU_HALT_O)
            rd_n <= 4'h0;
         else if (MEM_RD_O)
            rd_n <= rd_n + 4'h1;
      end
   end

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   property p_rd_wr;
      MEM_RD_O |=> MEM_WR_O && !MEM_RD_O;
   endproperty
   a_rd_wr: assert property (p_rd_wr)
      else $error("read not followed by write");
   property p_halted;
      MEM_RD_O || MEM_WR_O |-> CPU_HALT_O;
   endproperty
   a_halted: assert property (p_halted)
      else $error("bus cycle without halt");
   property p_halt_start;
      $rose(CPU_HALT_O) |-> MEM_RD_O;
   endproperty
   a_halt_start: assert property (p_halt_start)
      else $error("halt without read");
   property p_gap;
      $fell(CPU_HALT_O) && ENABLE_O && mode_q[2:1] == 2'b01
         |-> rd_n == 4'h4 ##1 !CPU_HALT_O ##1 (CPU_HALT_O && MEM_RD_O);
   endproperty
   a_gap: assert property (p_gap)
      else $error("burst gap wrong");
   property p_oneshot;
      $rose(DONE_O) && !mode_q[2] |-> !ENABLE_O && !CPU_HALT_O;
   endproperty
   a_oneshot: assert property (p_oneshot)
      else $error("enable kept after one-shot");
   property p_rep_keep;
      $rose(DONE_O) && mode_q[2] && $past(ENABLE_O) |-> ENABLE_O;
   endproperty
   a_rep_keep: assert property (p_rep_keep)
      else $error("enable lost in repeated mode");
   property p_relaunch;
      $rose(DONE_O) && mode_q[2:1] == 2'b11 && $past(ENABLE_O) |-> ##[0:3] MEM_RD_O;
   endproperty
   a_relaunch: assert property (p_relaunch)
      else $error("repeated burst did not relaunch");
   property p_byte_wr;
      MEM_WR_O && MEM_BYTE_O |-> MEM_WDATA_O[15:8] == 8'h00;
   endproperty
   a_byte_wr: assert property (p_byte_wr)
      else $error("byte write upper lane not zero");
   property p_single;
      MEM_WR_O && mode_q[1:0] == 2'b00 |=> !CPU_HALT_O && !MEM_RD_O;
   endproperty
   a_single: assert property (p_single)
      else $error("single mode moved more than one");
endmodule : dma_transfer_mode_engine_sva

bind dma_transfer_mode_engine dma_transfer_mode_engine_sva #(
   .ADDR_W(ADDR_W), .CNT_W(CNT_W), .TRIG_N(TRIG_N)
) u_sva (
   .CLK_I(CLK_I), .RST_I(RST_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
   .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
   .TRIG_I(TRIG_I), .NMI_I(NMI_I), .MEM_ADDR_O(MEM_ADDR_O), .MEM_RD_O(MEM_RD_O),
   .MEM_WR_O(MEM_WR_O), .MEM_BYTE_O(MEM_BYTE_O), .MEM_WDATA_O(MEM_WDATA_O),
   .MEM_RDATA_I(MEM_RDATA_I), .CPU_HALT_O(CPU_HALT_O), .DONE_O(DONE_O),
   .ENABLE_O(ENABLE_O)
);
`default_nettype wire

// ==== test/dma_transfer_mode_engine_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module dma_transfer_mode_engine_test;
   import dma_pkg::*;
   logic        clk, rst, reg_wr, reg_rd, nmi, mem_rd, mem_wr, mem_byte, halt, done, enable;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, trig, mem_addr, mem_wdata, mem_rdata;
   logic [15:0] wr_addr, wr_data, d;
   int          error_cnt = 0;
   int          total_checks = 0;
   int          halt_cnt = 0;
   int          wr_cnt, n, h;

   dma_transfer_mode_engine DUT (
      .CLK_I(clk), .RST_I(rst), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata),
      .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata), .TRIG_I(trig),
      .NMI_I(nmi), .MEM_ADDR_O(mem_addr), .MEM_RD_O(mem_rd), .MEM_WR_O(mem_wr),
      .MEM_BYTE_O(mem_byte), .MEM_WDATA_O(mem_wdata), .MEM_RDATA_I(mem_rdata),
      .CPU_HALT_O(halt), .DONE_O(done), .ENABLE_O(enable));
   dma_mem_model u_mem (
      .clk_i(clk), .rst_i(rst), .rd_i(mem_rd), .wr_i(mem_wr), .addr_i(mem_addr),
      .wdata_i(mem_wdata), .rdata_o(mem_rdata), .wr_cnt_o(wr_cnt),
      .wr_addr_o(wr_addr), .wr_data_o(wr_data));

   always @(negedge clk)
      if (halt === 1'b1)
         halt_cnt++;

   // ------
   // Helpers
   // ------
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rchk(input string nm, input logic [3:0] a, input logic [15:0] exp);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      chk(nm, d, exp);
      @(posedge clk);
   endtask : rchk
   task automatic flg(input logic e, input logic dn);
      chk("flags", {14'h0000, enable, done}, {14'h0000, e, dn});
   endtask : flg
   task automatic setup(input logic [15:0] s, t, c, ctl);
      wr(SRC_OFS, s);
      wr(DST_OFS, t);
      wr(CNT_OFS, c);
      n = wr_cnt;
      h = halt_cnt;
      wr(CTRL_OFS, ctl);
   endtask : setup

   // ------
   // Scenarios
   // ------
   task automatic reg_test;
      rchk("ctrl", CTRL_OFS, CTRL_RESET);
      rchk("cnt", CNT_OFS, CNT_RESET);
      rchk("tsel", TSEL_OFS, 16'(TSEL_RESET));
      wr(SRC_OFS, 16'h1234);
      rchk("src", SRC_OFS, 16'h1234);
      rchk("unmapped", 4'hE, 16'h0000);
   endtask : reg_test
   task automatic single_test;
      setup(16'h0134, 16'h0200, 16'h0002, 16'h0D78);
      cyc(8);
      chk("writes", 16'(wr_cnt - n), 16'h0001);
      chk("waddr", wr_addr, 16'h0200);
      chk("wdata", wr_data, 16'h0034);
      flg(1'b1, 1'b0);
      rchk("cnt", CNT_OFS, 16'h0001);
      rd_req();
      wr(CTRL_OFS, 16'h0D78);
      cyc(8);
      chk("waddr", wr_addr, 16'h0201);
      chk("wdata", wr_data, 16'h0036);
      flg(1'b0, 1'b1);
      rchk("cnt", CNT_OFS, 16'h0002);
      rchk("src", SRC_OFS, 16'h0134);
      wr(CTRL_OFS, 16'h0978);
      cyc(8);
      chk("writes", 16'(wr_cnt - n), 16'h0002);
   endtask : single_test
   task automatic rd_req;
      rchk("req", CTRL_OFS, 16'h0578);
   endtask : rd_req
   task automatic zero_test;
      setup(16'h0010, 16'h0400, 16'h0000, 16'h0C71);
      cyc(10);
      chk("writes", 16'(wr_cnt - n), 16'h0000);
      chk("halt", 16'(halt_cnt - h), 16'h0000);
   endtask : zero_test
   task automatic block_test;
      wr(CTRL_OFS, 16'h0000);
      wr(TSEL_OFS, 16'h0005);
      setup(16'h0050, 16'h0300, 16'h0003, 16'h04F1);
      trig <= 16'h0020;
      cyc(2);
      trig <= 16'h0000;
      cyc(2);
      trig <= 16'h0020;
      cyc(2);
      trig <= 16'h0000;
      cyc(16);
      chk("writes", 16'(wr_cnt - n), 16'h0003);
      chk("waddr", wr_addr, 16'h0304);
      chk("wdata", wr_data, 16'h004E);
      chk("halt", 16'(halt_cnt - h), 16'h0006);
      flg(1'b0, 1'b1);
      wr(TSEL_OFS, 16'h0000);
   endtask : block_test
   task automatic rep_test;
      for (int i = 0; i < 2; i++) begin
         setup(16'h0010, 16'h0400, 16'(i + 1), 16'(16'h0C7C + i));
         cyc(12);
         chk("writes", 16'(wr_cnt - n), 16'(i + 1));
         flg(1'b1, 1'b1);
         wr(CTRL_OFS, 16'(16'h0C7C + i));
         cyc(12);
         chk("writes", 16'(wr_cnt - n), 16'(2 * i + 2));
      end
   endtask : rep_test
   task automatic burst_test;
      setup(16'h0020, 16'h0500, 16'h0006, 16'h0C7A);
      cyc(30);
      chk("writes", 16'(wr_cnt - n), 16'h0006);
      chk("halt", 16'(halt_cnt - h), 16'h000C);
      flg(1'b0, 1'b1);
   endtask : burst_test
   task automatic rep_burst_test;
      setup(16'h0020, 16'h0500, 16'h0003, 16'h2C7E);
      cyc(30);
      chk("relaunch", 16'(wr_cnt - n > 3), 16'h0001);
      flg(1'b1, 1'b1);
      nmi <= 1'b1;
      cyc(4);
      nmi <= 1'b0;
      cyc(6);
      n = wr_cnt;
      cyc(10);
      chk("writes", 16'(wr_cnt - n), 16'h0000);
      chk("en", {15'h0000, enable}, 16'h0000);
      wr(CTRL_OFS, 16'h2C7E);
      cyc(20);
      wr(CTRL_OFS, 16'h007E);
      cyc(6);
      n = wr_cnt;
      cyc(10);
      chk("writes", 16'(wr_cnt - n), 16'h0000);
   endtask : rep_burst_test
   task automatic stale_test;
      trig <= 16'h0008;
      wr(TSEL_OFS, 16'h0003);
      setup(16'h0030, 16'h0600, 16'h0001, 16'h0478);
      cyc(10);
      chk("writes", 16'(wr_cnt - n), 16'h0000);
      trig <= 16'h0000;
      cyc(3);
      trig <= 16'h0008;
      cyc(10);
      chk("writes", 16'(wr_cnt - n), 16'h0001);
      wr(CTRL_OFS, 16'h0678);
      cyc(10);
      chk("writes", 16'(wr_cnt - n), 16'h0002);
   endtask : stale_test

   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      rst       = 1'b1;
      reg_addr  = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      trig      = 16'h0000;
      nmi       = 1'b0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      reg_test();
      single_test();
      zero_test();
      block_test();
      rep_test();
      burst_test();
      rep_burst_test();
      stale_test();
      summarize();
   end
   initial begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      summarize();
   end
endmodule : dma_transfer_mode_engine_test
`default_nettype wire
